// [core/msp_uart_map.vh]
// register map, field positions and timing constants of the serial port
// Behaviour
// - one location: write transmit, read receive buffer
// - mode 0 shifts 8 bits lsb first, clk/12
// - mode 1 frame: start 0, 8 data, stop 1
// - mode 1 keeps stop bit in rx ninth
// - modes 1,3: timer1 rate*2^doubler/32 or timer2/16
// - modes 2,3: eleven bits with ninth bit
// - mode 2 rate clk/64, or /32 doubled
// - buffer write starts transmission in every mode
// - mode 0 receives while rx done 0, enabled
// - async receive starts on falling edge if enabled
// - mode bits high,low decode modes 0..3
// - framing error sticky until software clears
// - filter modes 2,3: ninth 1 and address match
// - filter mode 1: valid stop and address match
// - mask bit 1 compares station bit, 0 ignores
// - address filter ignored in mode 0
// - tx done set when transmission ends
// - rx done set when reception ends, filtered
// - receive starts only while receive enable set; async receive stops when it clears
// - one interrupt from tx or rx done
// - done flags cleared only by software
// - clock select picks timer2 when 1
`ifndef MSP_UART_MAP_VH
`define MSP_UART_MAP_VH

`define MSP_OFS_CTRL   5'h00
`define MSP_OFS_BUF    5'h04
`define MSP_OFS_STATION_ADDRESS  5'h08
`define MSP_OFS_SMASK  5'h0C
`define MSP_OFS_PWR    5'h10
`define MSP_OFS_CLKSEL 5'h14

`define MSP_SC_B7  7
`define MSP_SC_SML 6
`define MSP_SC_AFE 5
`define MSP_SC_REN 4
`define MSP_SC_TB8 3
`define MSP_SC_RB8 2
`define MSP_SC_TI  1
`define MSP_SC_RI  0
`define MSP_PWR_DBL 7
`define MSP_PWR_FES 6
`define MSP_CS_TX  0
`define MSP_CS_RX  1

`define MSP_RST_BYTE 8'h00

`define MSP_MODE0 2'h0
`define MSP_MODE1 2'h1
`define MSP_MODE2 2'h2
`define MSP_MODE3 2'h3

`define MSP_M0_LAST 4'hB
`define MSP_M0_HALF 4'h6
`define MSP_SUB_LAST 4'hF
`define MSP_SMP_A 4'h7
`define MSP_SMP_B 4'h8
`define MSP_SMP_C 4'h9
`define MSP_BITS8 4'h8
`define MSP_BITS10 4'hA
`define MSP_BITS11 4'hB
`define MSP_IDX_NINTH 4'h9
`define MSP_IDX_STOP2 4'hA

`endif

// [core/msp_uart.v]
// multimode serial port with avalon-mm register slave
//
// Implementation choices: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "msp_uart_map.vh"

module msp_uart (
  input  wire        clk,           // 200 MHz clock, also bit-rate source
  input  wire        rst_n,         // async reset, active low
  input  wire [4:0]  avs_address,   // byte address
  input  wire        avs_read,      // read request
  input  wire        avs_write,     // write request
  input  wire [31:0] avs_writedata, // write data
  output reg  [31:0] avs_readdata,  // read data
  output reg         avs_waitrequest, // stall
  input  wire        timer1_ovf,    // timer1 overflow pulse
  input  wire        timer2_ovf,    // timer2 overflow pulse
  input  wire        rxd_i,         // serial input pin level
  output reg         rxd_o,         // mode 0 data out
  output reg         rxd_oe,        // mode 0 data out enable
  output reg         txd_o,         // serial out or shift clock
  output reg         serial_irq     // tx or rx done
);

  localparam TX_IDLE = 2'h0;
  localparam TX_M0   = 2'h1;
  localparam TX_ASY  = 2'h2;
  localparam RX_IDLE = 2'h0;
  localparam RX_M0   = 2'h1;
  localparam RX_ASY  = 2'h2;

  // bit-rate tick at sixteen times the bit rate
  function pick_tick;
    input [1:0] mode;
    input       sel;
    input       t1;
    input       half;
    input       dbl;
    input       t2;
    input [1:0] cnt;
    begin
      if (mode == `MSP_MODE2) begin
        pick_tick = dbl ? cnt[0] : &cnt;
      end else if (sel) begin
        pick_tick = t2;
      end else begin
        pick_tick = t1 & (dbl | half);
      end
    end
  endfunction

  // given or broadcast address compare
  function addr_match;
    input [7:0] b;
    input [7:0] sa;
    input [7:0] sm;
    reg   [7:0] bc;
    begin
      bc = sa | sm;
      addr_match = (((b ^ sa) & sm) == 8'h00) |
                   (((b ^ bc) & bc) == 8'h00);
    end
  endfunction

  reg  [7:0] sc_q;
  reg        fe_q;
  reg  [7:0] station_address_q;
  reg  [7:0] smask_q;
  reg        dbl_q;
  reg        fes_q;
  reg  [1:0] csel_q;
  reg  [7:0] txbuf_q;
  reg  [7:0] rxbuf_q;
  reg        half_q;
  reg  [1:0] m2cnt_q;
  reg        rxs1_q;
  reg        rxs2_q;
  reg        rxp_q;

  reg  [1:0]  tx_st_q;
  reg  [10:0] tx_sh_q;
  reg  [3:0]  tx_left_q;
  reg  [3:0]  tx_sub_q;

  reg  [1:0]  rx_st_q;
  reg  [7:0]  rx_sh_q;
  reg  [3:0]  rx_idx_q;
  reg  [3:0]  rx_sub_q;
  reg  [1:0]  rx_smp_q;
  reg         rx_nin_q;

  wire [1:0] mode;
  wire       wr_ack;
  wire       rd_req;
  wire       wr_buf;
  wire       wr_ctrl;
  wire       tx_tick;
  wire       rx_tick;
  wire       rx_bit;
  wire       rx_fall;
  wire       ren;
  reg        ti_set;
  reg        ri_set;
  reg        fe_set;
  reg        rb8_set;
  reg        rb8_val;
  reg        rxbuf_ld;
  reg  [7:0] rxbuf_val;

  // mode pair read high then low
  assign mode = {sc_q[`MSP_SC_B7], sc_q[`MSP_SC_SML]};
  assign ren  = sc_q[`MSP_SC_REN];

  // bus decode: write acts at the edge that sees waitrequest low
  assign wr_ack  = avs_write & ~avs_waitrequest;
  assign rd_req  = avs_read & avs_waitrequest;
  assign wr_buf  = wr_ack & (avs_address == `MSP_OFS_BUF);
  assign wr_ctrl = wr_ack & (avs_address == `MSP_OFS_CTRL);

  // separate tx and rx rate sources
  assign tx_tick = pick_tick(mode, csel_q[`MSP_CS_TX], timer1_ovf, half_q,
                             dbl_q, timer2_ovf, m2cnt_q);
  assign rx_tick = pick_tick(mode, csel_q[`MSP_CS_RX], timer1_ovf, half_q,
                             dbl_q, timer2_ovf, m2cnt_q);

  // majority of three mid-bit samples
  assign rx_bit  = (rx_smp_q[1] & rx_smp_q[0]) | (rx_smp_q[1] & rxs2_q) |
                   (rx_smp_q[0] & rxs2_q);
  assign rx_fall = rxp_q & ~rxs2_q;

  // pin synchroniser and rate prescalers
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxs1_q  <= 1'b1;
      rxs2_q  <= 1'b1;
      rxp_q   <= 1'b1;
      half_q  <= 1'b0;
      m2cnt_q <= 2'h0;
    end else begin
      rxs1_q  <= rxd_i;
      rxs2_q  <= rxs1_q;
      rxp_q   <= rxs2_q;
      m2cnt_q <= m2cnt_q + 2'h1;
      if (timer1_ovf) begin
        half_q <= ~half_q;
      end
    end
  end

  // avalon slave: one wait cycle per access, unmapped reads zero
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
      if (rd_req) begin
        if (avs_address == `MSP_OFS_CTRL) begin
          avs_readdata <= {24'h000000, fes_q ? fe_q : sc_q[`MSP_SC_B7],
                           sc_q[6:0]};
        end else if (avs_address == `MSP_OFS_BUF) begin
          avs_readdata <= {24'h000000, rxbuf_q};
        end else if (avs_address == `MSP_OFS_STATION_ADDRESS) begin
          avs_readdata <= {24'h000000, station_address_q};
        end else if (avs_address == `MSP_OFS_SMASK) begin
          avs_readdata <= {24'h000000, smask_q};
        end else if (avs_address == `MSP_OFS_PWR) begin
          avs_readdata <= {24'h000000, dbl_q, fes_q, 6'h00};
        end else if (avs_address == `MSP_OFS_CLKSEL) begin
          avs_readdata <= {30'h00000000, csel_q};
        end else begin
          avs_readdata <= 32'h0000_0000;
        end
      end
    end
  end

  // software registers; hardware sets win over software clears
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sc_q    <= `MSP_RST_BYTE;
      fe_q    <= 1'b0;
      station_address_q <= `MSP_RST_BYTE;
      smask_q <= `MSP_RST_BYTE;
      dbl_q   <= 1'b0;
      fes_q   <= 1'b0;
      csel_q  <= 2'h0;
      txbuf_q <= `MSP_RST_BYTE;
      rxbuf_q <= `MSP_RST_BYTE;
    end else begin
      if (wr_ctrl) begin
        sc_q[6:0] <= avs_writedata[6:0];
        if (fes_q) begin
          fe_q <= avs_writedata[`MSP_SC_B7];
        end else begin
          sc_q[`MSP_SC_B7] <= avs_writedata[`MSP_SC_B7];
        end
      end
      if (wr_buf) begin
        txbuf_q <= avs_writedata[7:0];
      end
      if (wr_ack && avs_address == `MSP_OFS_STATION_ADDRESS) begin
        station_address_q <= avs_writedata[7:0];
      end
      if (wr_ack && avs_address == `MSP_OFS_SMASK) begin
        smask_q <= avs_writedata[7:0];
      end
      if (wr_ack && avs_address == `MSP_OFS_PWR) begin
        dbl_q <= avs_writedata[`MSP_PWR_DBL];
        fes_q <= avs_writedata[`MSP_PWR_FES];
      end
      if (wr_ack && avs_address == `MSP_OFS_CLKSEL) begin
        csel_q <= avs_writedata[1:0];
      end
      if (ti_set) begin
        sc_q[`MSP_SC_TI] <= 1'b1;
      end
      if (ri_set) begin
        sc_q[`MSP_SC_RI] <= 1'b1;
      end
      if (rb8_set) begin
        sc_q[`MSP_SC_RB8] <= rb8_val;
      end
      if (fe_set) begin
        fe_q <= 1'b1;
      end
      if (rxbuf_ld) begin
        rxbuf_q <= rxbuf_val;
      end
    end
  end

  // interrupt request from either done flag
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_irq <= 1'b0;
    end else begin
      serial_irq <= sc_q[`MSP_SC_TI] | sc_q[`MSP_SC_RI];
    end
  end

  // transmitter: any buffer write (re)starts a frame
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_st_q   <= TX_IDLE;
      tx_sh_q   <= 11'h7FF;
      tx_left_q <= 4'h0;
      tx_sub_q  <= 4'h0;
      txd_o     <= 1'b1;
      rxd_o     <= 1'b1;
      rxd_oe    <= 1'b0;
      ti_set    <= 1'b0;
    end else begin
      ti_set <= 1'b0;
      if (wr_buf) begin
        tx_sub_q <= 4'h0;
        if (mode == `MSP_MODE0) begin
          tx_st_q   <= TX_M0;
          tx_sh_q   <= {3'h7, avs_writedata[7:0]};
          tx_left_q <= `MSP_BITS8;
          rxd_o     <= avs_writedata[0];
          rxd_oe    <= 1'b1;
          txd_o     <= 1'b0;
        end else begin
          tx_st_q <= TX_ASY;
          if (mode == `MSP_MODE1) begin
            tx_sh_q   <= {2'h3, avs_writedata[7:0], 1'b0};
            tx_left_q <= `MSP_BITS10;
          end else begin
            tx_sh_q   <= {1'b1, sc_q[`MSP_SC_TB8], avs_writedata[7:0],
                          1'b0};
            tx_left_q <= `MSP_BITS11;
          end
          txd_o <= 1'b0;
        end
      end else begin
        case (tx_st_q)
          TX_M0: begin
            // twelve clocks a bit: clock low half, high half
            tx_sub_q <= tx_sub_q + 4'h1;
            if (tx_sub_q == `MSP_M0_HALF - 4'h1) begin
              txd_o <= 1'b1;
            end
            if (tx_sub_q == `MSP_M0_LAST) begin
              tx_sub_q  <= 4'h0;
              tx_sh_q   <= {1'b1, tx_sh_q[10:1]};
              tx_left_q <= tx_left_q - 4'h1;
              rxd_o     <= tx_sh_q[1];
              if (tx_left_q == 4'h1) begin
                tx_st_q <= TX_IDLE;
                rxd_oe  <= 1'b0;
                rxd_o   <= 1'b1;
                ti_set  <= 1'b1;
              end else begin
                txd_o <= 1'b0;
              end
            end
          end
          TX_ASY: begin
            if (tx_tick) begin
              tx_sub_q <= tx_sub_q + 4'h1;
              if (tx_sub_q == `MSP_SUB_LAST) begin
                tx_sh_q   <= {1'b1, tx_sh_q[10:1]};
                tx_left_q <= tx_left_q - 4'h1;
                txd_o     <= tx_sh_q[1];
                if (tx_left_q == 4'h1) begin
                  tx_st_q <= TX_IDLE;
                  txd_o   <= 1'b1;
                  ti_set  <= 1'b1;
                end
              end
            end
          end
          TX_IDLE: begin
            // line idles high; mode 0 reception borrows the pin as its shift clock
            txd_o <= (rx_st_q != RX_M0) ||
                     (rx_sub_q >= `MSP_M0_HALF - 4'h1 &&
                      (rx_sub_q != `MSP_M0_LAST || rx_idx_q == `MSP_BITS8 - 4'h1));
          end
          default: begin
            tx_st_q <= TX_IDLE;
          end
        endcase
      end
    end
  end

  // receiver: mode 0 shift-in and async frames
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_st_q   <= RX_IDLE;
      rx_sh_q   <= `MSP_RST_BYTE;
      rx_idx_q  <= 4'h0;
      rx_sub_q  <= 4'h0;
      rx_smp_q  <= 2'h3;
      rx_nin_q  <= 1'b0;
      ri_set    <= 1'b0;
      fe_set    <= 1'b0;
      rb8_set   <= 1'b0;
      rb8_val   <= 1'b0;
      rxbuf_ld  <= 1'b0;
      rxbuf_val <= `MSP_RST_BYTE;
    end else begin
      ri_set   <= 1'b0;
      fe_set   <= 1'b0;
      rb8_set  <= 1'b0;
      rxbuf_ld <= 1'b0;
      case (rx_st_q)
        RX_IDLE: begin
          rx_sub_q <= 4'h0;
          rx_idx_q <= 4'h0;
          if (ren) begin
            if (mode == `MSP_MODE0) begin
              if (!sc_q[`MSP_SC_RI] && tx_st_q == TX_IDLE && !wr_buf &&
                  !ri_set) begin
                rx_st_q <= RX_M0;
              end
            end else if (rx_fall) begin
              rx_st_q <= RX_ASY;
            end
          end
        end
        RX_M0: begin
          // shift clock comes from the transmitter's clock pin logic
          rx_sub_q <= rx_sub_q + 4'h1;
          if (rx_sub_q == `MSP_M0_LAST) begin
            rx_sub_q <= 4'h0;
            rx_idx_q <= rx_idx_q + 4'h1;
            rx_sh_q  <= {rxs2_q, rx_sh_q[7:1]};
            if (rx_idx_q == `MSP_BITS8 - 4'h1) begin
              rx_st_q   <= RX_IDLE;
              rxbuf_ld  <= 1'b1;
              rxbuf_val <= {rxs2_q, rx_sh_q[7:1]};
              ri_set    <= 1'b1;
            end
          end
        end
        RX_ASY: begin
          if (!ren) begin
            rx_st_q <= RX_IDLE;
          end else if (rx_tick) begin
            rx_sub_q <= rx_sub_q + 4'h1;
            if (rx_sub_q == `MSP_SMP_A || rx_sub_q == `MSP_SMP_B) begin
              rx_smp_q <= {rx_smp_q[0], rxs2_q};
            end
            if (rx_sub_q == `MSP_SMP_C) begin
              rx_idx_q <= rx_idx_q + 4'h1;
              if (rx_idx_q == 4'h0) begin
                if (rx_bit) begin
                  rx_st_q <= RX_IDLE;
                end
              end else if (rx_idx_q <= `MSP_BITS8) begin
                rx_sh_q <= {rx_bit, rx_sh_q[7:1]};
              end else if (rx_idx_q == `MSP_IDX_NINTH &&
                           mode != `MSP_MODE1) begin
                rx_nin_q <= rx_bit;
              end else begin
                // stop bit: finish the frame at mid-bit
                rx_st_q <= RX_IDLE;
                fe_set  <= ~rx_bit;
                if (!sc_q[`MSP_SC_AFE] ||
                    (addr_match(rx_sh_q, station_address_q, smask_q) &&
                     (mode == `MSP_MODE1 ? rx_bit : rx_nin_q))) begin
                  ri_set    <= 1'b1;
                  rb8_set   <= 1'b1;
                  rb8_val   <= (mode == `MSP_MODE1) ? rx_bit : rx_nin_q;
                  rxbuf_ld  <= 1'b1;
                  rxbuf_val <= rx_sh_q;
                end
              end
            end
          end
        end
        default: begin
          rx_st_q <= RX_IDLE;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// [verification/msp_uart_assertions.sv]
// bus and pin timing checks of the serial port
`timescale 1ns/1ps
`default_nettype none
`include "msp_uart_map.vh"
module msp_uart_assertions (
  input wire logic        clk,             // clock
  input wire logic        rst_n,           // reset, active low
  input wire logic [4:0]  avs_address,     // byte address
  input wire logic        avs_read,        // read request
  input wire logic        avs_write,       // write request
  input wire logic [31:0] avs_readdata,    // read data
  input wire logic        avs_waitrequest, // stall
  input wire logic        rxd_o,           // mode 0 data
  input wire logic        rxd_oe,          // mode 0 data enable
  input wire logic        txd_o,           // line or shift clock
  input wire logic        serial_irq       // interrupt
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // request pending, and request completing at this edge
  wire req = avs_read || avs_write;
  wire acc = req && !avs_waitrequest;
  wire wr_done = acc && avs_write;
  // low and high halves of one mode 0 shift clock period
  sequence s_clk_low;
    !txd_o [*6];
  endsequence
  sequence s_clk_high;
    txd_o [*6];
  endsequence
  a_bus_answers: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered");
  a_wait_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  a_unmapped_zero: assert property (acc && avs_read && avs_address[1:0] != 2'h0 |->
    avs_readdata == 32'h0) else $error("unmapped read not zero");
  a_upper_zero: assert property (acc && avs_read |-> avs_readdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_tx_starts: assert property (wr_done && avs_address == `MSP_OFS_BUF |=> !txd_o)
    else $error("buffer write did not start a transfer");
  a_shift_clock: assert property ($rose(rxd_oe) |-> s_clk_low ##1 s_clk_high)
    else $error("mode 0 shift clock period wrong");
  a_data_hold: assert property (rxd_oe && txd_o |-> $stable(rxd_o))
    else $error("mode 0 data moved while clock high");
  a_eight_bits: assert property ($rose(rxd_oe) |-> ##95 rxd_oe ##[1:30] !rxd_oe)
    else $error("mode 0 transfer length wrong");
  a_irq_sw_clear: assert property ($fell(serial_irq) |->
    $past(wr_done) || $past(wr_done, 2) || $past(wr_done, 3))
    else $error("interrupt dropped without a write");
endmodule
bind msp_uart msp_uart_assertions u_chk (
  .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .rxd_o(rxd_o), .rxd_oe(rxd_oe), .txd_o(txd_o), .serial_irq(serial_irq));
`default_nettype wire

// [verification/msp_uart_node.sv]
// remote serial node: sends frames to the port and captures its frames
`timescale 1ns/1ps
`default_nettype none
module msp_uart_node (
  input  wire logic clk, // bench clock
  input  wire logic txd, // line from the port
  output var  logic rxd  // line to the port, idles high
);
  int          bit_clks = 32; // clocks per bit
  int          frames = 0;    // frames captured
  logic [10:0] last_frame;    // last frame seen, start bit at 0
  initial rxd = 1'b1;
  // start low, nbits lsb first, stop level, then one idle bit
  task automatic send(input logic [8:0] d, input int nbits, input logic stp);
    for (int i = -1; i <= nbits + 1; i++) begin
      rxd <= (i < 0) ? 1'b0 : (i == nbits) ? stp : (i > nbits) ? 1'b1 : d[i];
      repeat (bit_clks) @(posedge clk);
    end
  endtask
  // eleven mid-bit samples from each falling edge of the line
  initial forever begin
    @(negedge txd);
    repeat (bit_clks / 2) @(posedge clk);
    for (int i = 0; i < 11; i++) begin
      last_frame[i] = txd;
      repeat (bit_clks) @(posedge clk);
    end
    frames++;
  end
endmodule
`default_nettype wire

// [verification/msp_uart_tb.sv]
// self-checking bench of the multimode serial port
`timescale 1ns/1ps
`default_nettype none
`include "msp_uart_map.vh"
module msp_uart_tb;
  logic        clk = 1'b0;    // 200 MHz clock
  logic        rst_n;         // reset, active low
  logic [4:0]  avs_address;   // byte address
  logic        avs_read;      // read strobe
  logic        avs_write;     // write strobe
  logic [31:0] avs_writedata; // write data
  logic        tick = 1'b0;   // overflow pulse of both timers
  logic        tp;            // last sampled shift clock level
  wire  [31:0] avs_readdata;  // read data
  wire         avs_waitrequest;
  wire         rxd_o;
  wire         rxd_oe;
  wire         txd_o;
  wire         serial_irq;
  wire         node_rxd;
  wire         rxd_pin = rxd_oe ? rxd_o : node_rxd; // shared data pin
  int          errors;
  int          tests_run;
  int          n;
  int          nb;
  logic        rb;
  logic [31:0] q;
  logic [31:0] c;
  logic [23:0] e;
  logic [7:0]  m0;
  // transmit cases: power, clock select, control, data
  logic [31:0] ttab [4] = '{32'h80_00_88_5A, 32'h00_00_80_81, 32'h80_00_40_C3, 32'h80_03_C8_0F};
  logic [10:0] tfrm [4] = '{11'h6B4, 11'h502, 11'h786, 11'h61E};
  int          tbit [4] = '{32, 64, 32, 32};
  // receive cases: control, {accept, stop}, ninth bit and data
  logic [23:0] rtab [9] = '{24'h98_3_13C, 24'h88_1_155, 24'hB8_3_14A, 24'hB8_1_150,
    24'hB8_1_04A, 24'hB8_3_1F7, 24'h50_3_0A7, 24'h70_0_04A, 24'h70_3_04A};

  always #2.5 clk = ~clk;
  // overflow pulse every second clock
  always @(posedge clk) tick <= rst_n & ~tick;

  msp_uart dut (
    .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .timer1_ovf(tick), .timer2_ovf(tick),
    .rxd_i(rxd_pin), .rxd_o(rxd_o), .rxd_oe(rxd_oe), .txd_o(txd_o), .serial_irq(serial_irq));
  msp_uart_node node (.clk(clk), .txd(txd_o), .rxd(node_rxd));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one access, held until waitrequest is sampled low; only the watchdog ends a stall
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] x);
    bus(1'b0, a, 8'h00);
    chk(q, x);
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // watchdog for a hung run
  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    final_report();
  end

  initial begin
    rst_n = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    errors = 0;
    tests_run = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // reset values, storage and unmapped places
    rd(`MSP_OFS_CTRL, 32'h0);
    bus(1'b1, `MSP_OFS_STATION_ADDRESS, 8'hA5);
    rd(`MSP_OFS_STATION_ADDRESS, 32'hA5);
    bus(1'b1, 5'h01, 8'hFF);
    rd(5'h01, 32'h0);
    rd(5'h18, 32'h0);
    $display("test registers done");
    // transmit in modes 1 to 3 at each rate source
    foreach (ttab[i]) begin
      c = ttab[i];
      node.bit_clks = tbit[i];
      bus(1'b1, `MSP_OFS_PWR, c[31:24]);
      bus(1'b1, `MSP_OFS_CLKSEL, c[23:16]);
      bus(1'b1, `MSP_OFS_CTRL, c[15:8]);
      n = node.frames;
      bus(1'b1, `MSP_OFS_BUF, c[7:0]);
      repeat (16 * tbit[i]) if (node.frames == n) @(posedge clk);
      chk(node.last_frame, tfrm[i]);
      rd(`MSP_OFS_CTRL, {24'h0, c[15:8] | 8'h02});
      chk(serial_irq, 1'b1);
      bus(1'b1, `MSP_OFS_CTRL, c[15:8]);
      @(posedge clk);
      chk(serial_irq, 1'b0);
    end
    $display("test transmit done");
    // reception, enable and address filtering
    bus(1'b1, `MSP_OFS_STATION_ADDRESS, 8'h40);
    bus(1'b1, `MSP_OFS_SMASK, 8'hF0);
    foreach (rtab[i]) begin
      e = rtab[i];
      nb = (e[23:22] == 2'b01) ? 8 : 9;
      rb = (nb == 8) ? e[12] : e[8];
      bus(1'b1, `MSP_OFS_CTRL, e[23:16]);
      node.send(e[8:0], nb, e[12]);
      rd(`MSP_OFS_CTRL, {24'h0, e[23:16] | (e[13] ? {5'h0, rb, 2'h1} : 8'h0)});
      if (e[13]) rd(`MSP_OFS_BUF, {24'h0, e[7:0]});
    end
    $display("test receive done");
    // sticky framing error seen through bit 7
    bus(1'b1, `MSP_OFS_PWR, 8'hC0);
    rd(`MSP_OFS_CTRL, 32'hF5);
    bus(1'b1, `MSP_OFS_CTRL, 8'h50);
    rd(`MSP_OFS_CTRL, 32'h50);
    $display("test framing done");
    // mode 0 shift out, sampled at each shift clock rise
    bus(1'b1, `MSP_OFS_CTRL, 8'h00);
    bus(1'b1, `MSP_OFS_BUF, 8'h96);
    for (int i = 0; i < 8; i++) begin
      @(posedge txd_o);
      m0[i] = rxd_o;
    end
    chk(m0, 8'h96);
    $display("test mode 0 done");
    // mode 0 shift in with the filter set: line idles high, eight clock rises
    repeat (12) @(posedge clk);
    bus(1'b1, `MSP_OFS_CTRL, 8'h30);
    tp = 1'b1;
    n = 0;
    repeat (120) begin
      @(posedge clk);
      if (txd_o && !tp) n++;
      tp = txd_o;
    end
    chk(n, 8);
    rd(`MSP_OFS_CTRL, 32'h31);
    rd(`MSP_OFS_BUF, 32'hFF);
    $display("test mode 0 receive done");
    final_report();
  end
endmodule
`default_nettype wire
